// ### src/aux_control_pkg.sv
// constants for the auxiliary control register and timer
package aux_control_pkg;
   localparam int TMR_W        = 16;
   localparam int BIT_RUN      = 7;
   localparam int BIT_LOAD     = 6;
   localparam int BIT_PRESCALE = 5;
   localparam int BIT_DIR      = 4;
   localparam int BIT_SLOW     = 3;
   localparam int BIT_CLKDIS   = 2;
   localparam int BIT_LOCKOUT  = 1;
   localparam int BIT_GIE      = 0;
   localparam int CCR_ZERO     = 7;
   localparam int MASK_PIN     = 3;
   localparam logic [7:0] ACR_RESET   = 8'h00;
   localparam logic [7:0] RD_MASK     = 8'hf7;
   localparam logic [3:0] DIV_SLOW    = 4'hf;
   localparam logic [3:0] DIV_FAST    = 4'h1;
   localparam logic [3:0] DIV_ZERO    = 4'h0;
   localparam logic [2:0] RD_TS_FAST  = 3'h3;
   localparam logic [2:0] RD_TS_SLOW  = 3'h4;
   localparam logic [15:0] TMR_ZERO   = 16'h0000;
endpackage

// ### src/timer_prescale.sv
// prescaler: one-cycle tick every 2 or 16 core clocks
`timescale 1ns/1ps
module timer_prescale
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   input  wire logic fast_i,
   output logic      tick_o
);
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   wire  [3:0] limit = fast_i ? aux_control_pkg::DIV_FAST
                              : aux_control_pkg::DIV_SLOW; // RQ3
   wire        wrap  = (cnt_ff >= limit);
   assign nxt_cnt = (!run_i || wrap) ? aux_control_pkg::DIV_ZERO
                                     : cnt_ff + 4'h1;
   assign tick_o  = run_i && wrap;
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         cnt_ff <= aux_control_pkg::DIV_ZERO;
      else
         cnt_ff <= nxt_cnt;
   end
endmodule

// ### src/aux_control_register.sv
// auxiliary control register with its timer, pin and gating effects
// Contract
// RQ1: run bit high makes the timer count down; low halts it
// RQ2: writing load bit pulses a timer load; bit self-clears after load
// RQ3: prescale bit 0 gives clock/16, bit 1 gives clock/2
// RQ4: software keeps prescale steady while the timer runs
// RQ5: direction bit 0 makes interrupt pin input, 1 output
// RQ6: clock-out disable bit floats the clock output pin
// RQ7: lockout bit refuses every remote host access
// RQ8: global enable low blocks all maskable interrupts, else masks decide; the pin mask bit is ignored while the pin drives
// RQ9: slow read bit stretches data-memory reads to four T-states
// RQ10: remote config register reachable by remote host only
// RQ11: zero flag sets at zero; clears by writing one or stopping
// RQ12: pin as output takes its level from its mask bit
// RQ13: load pulse copies timer high and low bytes into the counter
`timescale 1ns/1ps
module aux_control_register
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        acr_wr_i,
   input  wire logic [7:0]  acr_wdata_i,
   output logic      [7:0]  acr_rdata_o,
   input  wire logic        zero_flag_clr_i,
   output logic             timer_zero_flag_o,
   input  wire logic [15:0] timer_reload_i,
   output logic      [15:0] timer_count_o,
   input  wire logic [4:0]  irq_mask_bits_i,
   input  wire logic [4:0]  irq_pending_i,
   output logic      [4:0]  irq_enabled_o,
   input  wire logic        irq_pin_i,
   output logic             irq_pin_o,
   output logic             irq_pin_oe_o,
   output logic             irq_pin_level_o,
   input  wire logic        cpu_clk_i,
   output logic             clkout_o,
   output logic             clkout_oe_o,
   input  wire logic        remote_req_i,
   input  wire logic        remote_cfg_sel_i,
   output logic             remote_grant_o,
   output logic             remote_cfg_access_o,
   output logic      [2:0]  read_tstates_o,
   output logic             read_strobe_delay_o
);
   logic [7:0]  acr_ff;
   logic [7:0]  nxt_acr;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic        zero_ff;
   logic        nxt_zero;
   logic        pin_s1_ff;
   logic        pin_s2_ff;
   logic        tick;

   wire run      = acr_ff[aux_control_pkg::BIT_RUN];
   wire load     = acr_ff[aux_control_pkg::BIT_LOAD];
   wire fast     = acr_ff[aux_control_pkg::BIT_PRESCALE];
   wire pin_out  = acr_ff[aux_control_pkg::BIT_DIR];
   wire slow_rd  = acr_ff[aux_control_pkg::BIT_SLOW];
   wire clk_dis  = acr_ff[aux_control_pkg::BIT_CLKDIS];
   wire lockout  = acr_ff[aux_control_pkg::BIT_LOCKOUT];
   localparam logic [15:0] TMR_ONE = 16'h0001;
   wire global_irq_enable      = acr_ff[aux_control_pkg::BIT_GIE];
   wire hit_zero = run && tick && (cnt_ff == TMR_ONE);

   timer_prescale u_prescale
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .run_i      (run),
      .fast_i     (fast),
      .tick_o     (tick)
   );

   // register write; load bit self-clears after the load cycle
   always_comb
   begin
      nxt_acr = acr_ff;
      if (load)
         nxt_acr[aux_control_pkg::BIT_LOAD] = 1'b0; // RQ2
      if (acr_wr_i)
         nxt_acr = acr_wdata_i;
   end

   // load wins over counting; count only while running
   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (load)
         nxt_cnt = timer_reload_i; // RQ13
      else if (run && tick && cnt_ff != aux_control_pkg::TMR_ZERO)
         nxt_cnt = cnt_ff - 16'h0001; // RQ1
   end

   // set wins over clear
   always_comb
   begin
      nxt_zero = zero_ff;
      if (zero_flag_clr_i || !run)
         nxt_zero = 1'b0; // RQ11
      if (hit_zero)
         nxt_zero = 1'b1; // RQ11
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         acr_ff    <= aux_control_pkg::ACR_RESET;
         cnt_ff    <= aux_control_pkg::TMR_ZERO;
         zero_ff   <= 1'b0;
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
      end
      else
      begin
         acr_ff    <= nxt_acr;
         cnt_ff    <= nxt_cnt;
         zero_ff   <= nxt_zero;
         pin_s1_ff <= irq_pin_i;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // slow read bit is stored and acts, but reads back as zero
   assign acr_rdata_o       = acr_ff & aux_control_pkg::RD_MASK;
   assign timer_count_o     = cnt_ff;
   assign timer_zero_flag_o = zero_ff;

   // pin direction and level
   assign irq_pin_oe_o    = pin_out; // RQ5
   assign irq_pin_o       = irq_mask_bits_i[aux_control_pkg::MASK_PIN]; // RQ12
   assign irq_pin_level_o = pin_out ? irq_pin_o : pin_s2_ff;

   // interrupt gating; pin mask ignored while the pin drives
   wire [4:0] eff_mask = pin_out
      ? (irq_mask_bits_i & ~(5'h01 << aux_control_pkg::MASK_PIN)) // RQ12
      : irq_mask_bits_i;
   assign irq_enabled_o = global_irq_enable ? (irq_pending_i & ~eff_mask) : 5'h00; // RQ8

   assign clkout_o    = cpu_clk_i;
   assign clkout_oe_o = !clk_dis; // RQ6

   assign remote_grant_o      = remote_req_i && !lockout; // RQ7
   assign remote_cfg_access_o = remote_grant_o && remote_cfg_sel_i; // RQ10

   assign read_tstates_o = slow_rd ? aux_control_pkg::RD_TS_SLOW
                                   : aux_control_pkg::RD_TS_FAST; // RQ9
   assign read_strobe_delay_o = slow_rd; // RQ9

   a_load_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
      load && !acr_wr_i |=> !load && cnt_ff == $past(timer_reload_i))
      else $error("load bit not cleared or counter not loaded"); // RQ2
   a_halt_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run && !load |=> $stable(cnt_ff))
      else $error("timer moved while halted"); // RQ1
   a_fast_tick: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run && fast && tick && !acr_wr_i |=> !tick ##1 (tick || !run))
      else $error("fast prescale not divide by two"); // RQ3
   a_zero_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hit_zero && !load |=> zero_ff && cnt_ff == aux_control_pkg::TMR_ZERO)
      else $error("zero flag not set at zero"); // RQ11
   a_zero_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run && !hit_zero |=> !zero_ff)
      else $error("zero flag kept with timer stopped"); // RQ11
   a_gie_block: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !global_irq_enable |-> irq_enabled_o == 5'h00)
      else $error("interrupt passed with global enable low"); // RQ8
   a_lockout_refuse: assert property (@(posedge core_clk_i)
      disable iff (rst_i) lockout |-> !remote_grant_o && !remote_cfg_access_o)
      else $error("remote access while locked out"); // RQ7
   a_clkout_float: assert property (@(posedge core_clk_i) disable iff (rst_i)
      clk_dis |-> !clkout_oe_o)
      else $error("clock out driven while disabled"); // RQ6
   a_pin_dir: assert property (@(posedge core_clk_i) disable iff (rst_i)
      acr_wr_i |=> irq_pin_oe_o == $past(acr_wdata_i[4]))
      else $error("pin direction not from written bit"); // RQ5
   a_slow_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      acr_wr_i |=> read_tstates_o == ($past(acr_wdata_i[3]) ? 3'h4 : 3'h3))
      else $error("read length does not follow slow bit"); // RQ9

   a_wr_store: assert property (@(posedge core_clk_i) // RQ2
      disable iff (rst_i) acr_wr_i |=> acr_ff == $past(acr_wdata_i))
      else $error("written value not stored");

   a_count_load: assert property (@(posedge core_clk_i) // RQ13
      disable iff (rst_i) load |=> timer_count_o == $past(timer_reload_i))
      else $error("counter not loaded from reload value");

   a_run_count: assert property (@(posedge core_clk_i) // RQ1
      disable iff (rst_i)
      run && tick && !load && cnt_ff != aux_control_pkg::TMR_ZERO
      |=> cnt_ff == $past(cnt_ff) - TMR_ONE)
      else $error("timer did not step down on a tick");

   a_count_floor: assert property (@(posedge core_clk_i) // RQ1
      disable iff (rst_i) !load && cnt_ff == aux_control_pkg::TMR_ZERO
      |=> cnt_ff == aux_control_pkg::TMR_ZERO)
      else $error("timer moved below zero");

   a_zero_clear: assert property (@(posedge core_clk_i) // RQ11
      disable iff (rst_i) zero_flag_clr_i && !hit_zero |=> !zero_ff)
      else $error("zero flag not cleared by write of one");

   a_pin_input: assert property (@(posedge core_clk_i) // RQ5
      disable iff (rst_i) !pin_out |-> !irq_pin_oe_o
      && irq_pin_level_o == pin_s2_ff)
      else $error("input pin driven or level not synced");

   a_pin_unmask: assert property (@(posedge core_clk_i) // RQ12
      disable iff (rst_i) pin_out && global_irq_enable
      |-> irq_enabled_o[aux_control_pkg::MASK_PIN]
          == irq_pending_i[aux_control_pkg::MASK_PIN])
      else $error("pin mask bit masked while pin drives");

   a_mask_gate: assert property (@(posedge core_clk_i) // RQ8
      disable iff (rst_i) global_irq_enable && !pin_out
      |-> irq_enabled_o == (irq_pending_i & ~irq_mask_bits_i))
      else $error("mask bits not applied with global enable high");

   a_lockout_free: assert property (@(posedge core_clk_i) // RQ7
      disable iff (rst_i) !lockout |-> remote_grant_o == remote_req_i)
      else $error("remote access refused without lockout");

   a_cfg_remote: assert property (@(posedge core_clk_i) // RQ10
      disable iff (rst_i) remote_cfg_access_o
      |-> remote_req_i && remote_cfg_sel_i && !lockout)
      else $error("config access without remote grant");

   a_clkout_on: assert property (@(posedge core_clk_i) // RQ6
      disable iff (rst_i) !clk_dis |-> clkout_oe_o && clkout_o == cpu_clk_i)
      else $error("clock out not driven while enabled");
endmodule

// ### verif/tb_aux_control_register.sv
// testbench: register writes, timer, pin, clock-out and gating effects
`timescale 1ns/1ps
module tb_aux_control_register;
   logic        core_clk_i, rst_i, acr_wr_i, zero_flag_clr_i, irq_pin_i;
   logic        cpu_clk_i, remote_req_i, remote_cfg_sel_i, timer_zero_flag_o;
   logic        irq_pin_o, irq_pin_oe_o, irq_pin_level_o, clkout_o;
   logic        clkout_oe_o, remote_grant_o, remote_cfg_access_o;
   logic        read_strobe_delay_o;
   logic [2:0]  read_tstates_o;
   logic [7:0]  acr_wdata_i, acr_rdata_o;
   logic [15:0] timer_reload_i, timer_count_o, held;
   logic [4:0]  irq_mask_bits_i, irq_pending_i, irq_enabled_o;
   int          fail_count, checks, n;
   aux_control_register i_aux_control_register (.core_clk_i, .rst_i,
      .acr_wr_i, .acr_wdata_i, .acr_rdata_o, .zero_flag_clr_i,
      .timer_zero_flag_o, .timer_reload_i, .timer_count_o, .irq_mask_bits_i,
      .irq_pending_i, .irq_enabled_o, .irq_pin_i, .irq_pin_o, .irq_pin_oe_o,
      .irq_pin_level_o, .cpu_clk_i, .clkout_o, .clkout_oe_o, .remote_req_i,
      .remote_cfg_sel_i, .remote_grant_o, .remote_cfg_access_o,
      .read_tstates_o, .read_strobe_delay_o);
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic tick(input int c);
      repeat (c) @(posedge core_clk_i);
      #10;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      tick(1);
      acr_wr_i = 1'b1;
      acr_wdata_i = d;
      tick(1);
      acr_wr_i = 1'b0;
   endtask
   task automatic wait_flag(input int lim);
      n = 0;
      while (timer_zero_flag_o !== 1'b1 && n < lim)
      begin
         tick(1);
         n++;
      end
      chk(n < lim, 1'b1);
   endtask
   task automatic test_done();
      $display("counts: %0d checks, %0d mismatches", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      fail_count++;
      test_done();
   end
   initial
   begin
      {rst_i, acr_wr_i, zero_flag_clr_i, irq_pin_i, cpu_clk_i} = 5'h11;
      {remote_req_i, remote_cfg_sel_i} = 2'h3;
      acr_wdata_i = 8'h00;
      timer_reload_i = 16'h0005;
      irq_mask_bits_i = 5'h0a;
      irq_pending_i = 5'h1f;
      tick(5);
      rst_i = 1'b0;
      chk(acr_rdata_o, 8'h00);
      wr(8'he0);
      chk({acr_rdata_o, timer_count_o}, 24'he00000);
      tick(1);
      chk({acr_rdata_o, timer_count_o}, 24'ha00005);
      wait_flag(20);
      chk(timer_count_o, 16'h0000);
      zero_flag_clr_i = 1'b1;
      tick(1);
      zero_flag_clr_i = 1'b0;
      tick(1);
      chk(timer_zero_flag_o, 1'b0);
      timer_reload_i = 16'h0002;
      wr(8'hc0);
      tick(20);
      chk(timer_zero_flag_o, 1'b0);
      wait_flag(40);
      wr(8'h00);
      tick(1);
      chk(timer_zero_flag_o, 1'b0);
      $display("timer test done");
      timer_reload_i = 16'h0100;
      wr(8'he0);
      tick(4);
      wr(8'h20);
      held = timer_count_o;
      tick(10);
      chk(timer_count_o, held);
      chk(held < 16'h0100, 1'b1);
      $display("halt test done");
      wr(8'h1f);
      chk(acr_rdata_o, 8'h17);
      chk({irq_pin_oe_o, irq_pin_o, irq_pin_level_o}, 3'h7);
      chk({clkout_oe_o, remote_grant_o, remote_cfg_access_o}, 3'h0);
      chk(irq_enabled_o, 5'h1d);
      chk({read_tstates_o, read_strobe_delay_o}, 4'h9);
      irq_pin_i = 1'b1;
      wr(8'h01);
      tick(3);
      chk({irq_pin_oe_o, irq_pin_level_o, irq_enabled_o}, 7'h35);
      chk({clkout_oe_o, clkout_o, remote_grant_o}, 3'h7);
      chk(remote_cfg_access_o, 1'b1);
      remote_cfg_sel_i = 1'b0;
      wr(8'h08);
      chk({read_tstates_o, read_strobe_delay_o}, 4'h9);
      chk({irq_enabled_o, remote_cfg_access_o}, 6'h00);
      $display("control bit test done");
      test_done();
   end
endmodule
